// ### logic/bib_header_map.svh
// Offsets, field positions, reset values and constants of the bus info block header registers
`ifndef BIB_HEADER_MAP_SVH
`define BIB_HEADER_MAP_SVH
`define ROM_HDR_OFFSET 8'h18
`define BUS_IDENT_OFFSET 8'h1c
`define BUS_IDENT_VALUE 32'h31333934
`define ROM_HDR_UPPER_RESET 16'h0000
`define ROM_HDR_CRC_RESET 16'h0000
`define INFO_LEN_MSB 31
`define INFO_LEN_LSB 24
`define CRC_LEN_MSB 23
`define CRC_LEN_LSB 16
`define ROM_CRC_MSB 15
`define ROM_CRC_LSB 0
`define ROM_BASE_QUAD 6'h00
`define BIB_FIRST_QUAD 6'h01
`endif

// ### logic/bib_header_pkg.sv
// Types shared by the bus info block header registers
package bib_header_pkg;
    typedef struct packed {
        logic [7:0] info_length;
        logic [7:0] crc_length;
        logic [15:0] rom_crc_value;
    } rom_header_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sw_req_t;

    typedef enum logic [1:0] {
        LOAD_WAIT = 2'b01,
        LOAD_DONE = 2'b10
    } load_state_t;
endpackage

// ### logic/bib_header_regs.sv
// Configuration ROM header and bus identification registers
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "bib_header_map.svh"
module bib_header_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // EEPROM preload of the ROM CRC value
    input wire logic eeprom_present,
    input wire logic eeprom_crc_valid,
    input wire logic [15:0] eeprom_crc,
    // Remote node quadlet reads
    input wire logic remote_rd,
    input wire logic [5:0] remote_quad,
    output logic [31:0] remote_rdata,
    output logic remote_rvalid,
    // Status
    output logic crc_loaded
);
    bib_header_pkg::rom_header_t header;
    bib_header_pkg::load_state_t load_state;
    bib_header_pkg::sw_req_t req;

    // Bundle the software request
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Address decode
    wire logic hit_header = req.addr == `ROM_HDR_OFFSET;
    wire logic hit_ident = req.addr == `BUS_IDENT_OFFSET;
    wire logic header_wr = req.wr && hit_header;
    // Preload only once, and a software write in the same cycle wins since it is newer
    wire logic eeprom_take = (load_state == bib_header_pkg::LOAD_WAIT) && eeprom_present
                             && eeprom_crc_valid;
    wire logic [31:0] next_reg_rdata = hit_header ? header :
                                       hit_ident ? `BUS_IDENT_VALUE : 32'h00000000;

    // Header register; CRC field reset value is arbitrary when no EEPROM
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Upper half zero; CRC half a fixed pick, software must still write it
            header <= {`ROM_HDR_UPPER_RESET, `ROM_HDR_CRC_RESET};
        end else if (header_wr) begin
            header <= req.wdata;
        end else if (eeprom_take) begin
            header.rom_crc_value <= eeprom_crc;
        end
    end

    // Preload tracker: waits for the EEPROM word once after reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_state <= bib_header_pkg::LOAD_WAIT;
        end else begin
            unique case (load_state)
                bib_header_pkg::LOAD_WAIT: begin
                    if (eeprom_take || header_wr || !eeprom_present) begin
                        load_state <= bib_header_pkg::LOAD_DONE;
                    end
                end
                bib_header_pkg::LOAD_DONE: begin
                    load_state <= bib_header_pkg::LOAD_DONE;
                end
                default: begin
                    load_state <= bib_header_pkg::LOAD_DONE;
                end
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise; identifier writes drop
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
            crc_loaded <= 1'b0;
        end else begin
            reg_rdata <= req.rd ? next_reg_rdata : 32'h00000000;
            // A colliding software write wins, so that preload was not accepted
            crc_loaded <= crc_loaded | (eeprom_take && !header_wr);
        end
    end

    // Remote side answers from the live header
    rom_quad_port u_rom_quad_port (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .remote_rd(remote_rd),
        .remote_quad(remote_quad),
        .header_word(header),
        .remote_rdata(remote_rdata),
        .remote_rvalid(remote_rvalid)
    );

    sequence s_header_write;
        reg_wr && hit_header ##1 reg_rd && hit_header;
    endsequence

    chk_header_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_header_write |=> reg_rdata == $past(reg_wdata, 2))
        else $error("header write did not read back");
    chk_ident_constant: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_rd && hit_ident |=> reg_rdata == `BUS_IDENT_VALUE)
        else $error("bus identifier read wrong");
    chk_ident_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_wr && hit_ident |=> $stable(header))
        else $error("identifier write disturbed header");
    chk_eeprom_crc_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        eeprom_take && !header_wr |=> header.rom_crc_value == $past(eeprom_crc) && crc_loaded)
        else $error("eeprom crc not loaded");
    chk_no_eeprom_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !eeprom_present && !header_wr |=> $stable(header.rom_crc_value))
        else $error("crc changed without eeprom or write");
    chk_idle_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data not zero when idle");
    chk_load_once: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_state == bib_header_pkg::LOAD_DONE |=> load_state == bib_header_pkg::LOAD_DONE)
        else $error("preload re-armed");
    chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_rd && !hit_header && !hit_ident |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

// ### logic/rom_quad_port.sv
// Remote node read port of the first configuration ROM quadlets
`timescale 1ns/1ps
`include "bib_header_map.svh"
module rom_quad_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Remote quadlet read request
    input wire logic remote_rd,
    input wire logic [5:0] remote_quad,
    // Current register contents
    input wire logic [31:0] header_word,
    // Answer, one cycle after the request
    output logic [31:0] remote_rdata,
    output logic remote_rvalid
);
    // Quadlet select: header first, bus identifier second
    wire logic is_header = remote_quad == `ROM_BASE_QUAD;
    wire logic is_ident = remote_quad == `BIB_FIRST_QUAD;
    wire logic [31:0] next_remote_rdata = is_header ? header_word :
                                         is_ident ? `BUS_IDENT_VALUE : 32'h00000000;

    // Registered answer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remote_rdata <= 32'h00000000;
            remote_rvalid <= 1'b0;
        end else begin
            remote_rvalid <= remote_rd;
            if (remote_rd) begin
                remote_rdata <= next_remote_rdata;
            end
        end
    end

    chk_ident_quad_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
        remote_rd && is_ident |=> remote_rvalid && remote_rdata == `BUS_IDENT_VALUE)
        else $error("bus info block first quadlet wrong");
    chk_header_quad_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
        remote_rd && is_header |=> remote_rdata == $past(header_word))
        else $error("rom header quadlet wrong");
endmodule

// ### testbench/bib_header_regs_tb.sv
// Self-checking bench for the bus info block header registers
`timescale 1ns/1ps
`include "bib_header_map.svh"
module bib_header_regs_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic remote_rd = 1'b0;
    logic [5:0] remote_quad = 6'h00;
    logic present_cfg = 1'b1;
    logic [15:0] crc_cfg = 16'h5a3c;
    logic [31:0] reg_rdata, remote_rdata, hdr, d;
    logic [15:0] eeprom_crc;
    logic eeprom_present, eeprom_crc_valid, remote_rvalid, crc_loaded;
    int fail_count = 0;
    int n_checks = 0;
    integer seed = 14;
    always #50 core_clk = ~core_clk;
    bib_header_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eeprom_present(eeprom_present), .eeprom_crc_valid(eeprom_crc_valid),
        .eeprom_crc(eeprom_crc), .remote_rd(remote_rd), .remote_quad(remote_quad),
        .remote_rdata(remote_rdata), .remote_rvalid(remote_rvalid), .crc_loaded(crc_loaded));
    eeprom_model i_eeprom (.core_clk(core_clk), .rst_b(rst_b), .present_cfg(present_cfg),
        .crc_cfg(crc_cfg), .eeprom_present(eeprom_present),
        .eeprom_crc_valid(eeprom_crc_valid), .eeprom_crc(eeprom_crc));
    // Expected answer of a remote quadlet read
    function automatic logic [31:0] quad_exp(input logic [5:0] q, input logic [31:0] h);
        if (q == `ROM_BASE_QUAD) return h;
        if (q == `BIB_FIRST_QUAD) return `BUS_IDENT_VALUE;
        return 32'h0;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Strobe cycle, then an idle one in which read data stands
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v,
        output logic [31:0] q);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // Header write directly followed by its read, no idle cycle between
    task automatic wr_rd(input logic [31:0] v, output logic [31:0] q);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= `ROM_HDR_OFFSET;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic rq(input logic [5:0] qd, input logic [31:0] exp);
        @(posedge core_clk);
        remote_rd <= 1'b1;
        remote_quad <= qd;
        @(posedge core_clk);
        remote_rd <= 1'b0;
        #1 chk("remote_rvalid", 32'h1, {31'h0, remote_rvalid});
        chk("remote_rdata", exp, remote_rdata);
    endtask
    // Reset held five cycles, EEPROM attached or not
    task automatic do_reset(input logic pres);
        present_cfg <= pres;
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    task print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        acc(1'b0, `ROM_HDR_OFFSET, 32'h0, d);
        chk("header", {`ROM_HDR_UPPER_RESET, crc_cfg}, d);
        chk("crc_loaded", 32'h1, {31'h0, crc_loaded});
        for (int i = 0; i < 8; i++) begin
            hdr = $random(seed);
            acc(1'b1, `ROM_HDR_OFFSET, hdr, d);
            acc(1'b1, `BUS_IDENT_OFFSET, ~hdr, d);
            acc(1'b0, `ROM_HDR_OFFSET, 32'h0, d);
            chk("header", hdr, d);
            acc(1'b0, `BUS_IDENT_OFFSET, 32'h0, d);
            chk("ident", `BUS_IDENT_VALUE, d);
            wr_rd(hdr, d);
            chk("header b2b", hdr, d);
            rq(i[5:0] & 6'h03, quad_exp(i[5:0] & 6'h03, hdr));
        end
        rq(6'h3f, 32'h0);
        // Unmapped place: write dropped, read gives zero
        acc(1'b1, 8'h20, 32'hffffffff, d);
        acc(1'b0, 8'h20, 32'h0, d);
        chk("unmapped", 32'h0, d);
        acc(1'b0, `ROM_HDR_OFFSET, 32'h0, d);
        chk("header", hdr, d);
        do_reset(1'b0);
        acc(1'b0, `ROM_HDR_OFFSET, 32'h0, d);
        chk("header upper", 32'h0, {16'h0, d[31:16]});
        chk("crc_loaded", 32'h0, {31'h0, crc_loaded});
        print_verdict;
    end
endmodule

// ### testbench/eeprom_model.sv
// EEPROM loader stand-in that offers the ROM CRC preload
`timescale 1ns/1ps
module eeprom_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bench settings
    input wire logic present_cfg,
    input wire logic [15:0] crc_cfg,
    // Loader outputs
    output logic eeprom_present,
    output logic eeprom_crc_valid,
    output logic [15:0] eeprom_crc
);
    logic sent;
    // One offer per reset, like a loader finishing its single pass
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) sent <= 1'b0;
        else sent <= 1'b1;
    end
    assign eeprom_present = present_cfg;
    assign eeprom_crc_valid = present_cfg & rst_b & !sent;
    // Stale outside the offer, so show the inverse rather than a held value
    assign eeprom_crc = eeprom_crc_valid ? crc_cfg : ~crc_cfg;
endmodule
